// *** rtl/itt_timer.sv ***
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
module itt_timer
  import itt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Subclock and outputs
  input wire logic subclk_in,
  output logic irq_out,
  output logic clock_output_pin
);

  itt_apb_req_type req;
  itt_state_type s_q;
  itt_state_type s_d;

  // ----------------------------------------------------------------
  // Request bundle
  // ----------------------------------------------------------------
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic access;
    logic wr;
    logic hit;
    logic [29:0] idx;
    logic [7:0] rd;
    logic stby;
    logic tb_mode;
    logic sub_edge;
    logic sys_run;
    logic mode_wr_ok;
    logic run;
    logic tick;
    logic clr;
    logic ovf;
    logic [12:0] smask;
    logic [7:0] wmask;
    logic divided;
    logic div_ok;
    s_d = s_q;
    // Defaults, so no path leaves a stale value
    rd = ITT_BYTE_ZERO;
    run = 1'b0;
    tick = 1'b0;
    smask = ITT_PSS_D8;
    wmask = ITT_PSW_32ND;

    // --------------------------------------------------------------
    // Bus decode and operating conditions
    // --------------------------------------------------------------
    idx = req.paddr[31:2];
    access = req.psel && req.penable && !s_q.pready;
    wr = req.psel && req.penable && s_q.pready && req.pwrite;
    // module standby when bit is zero
    stby = !s_q.clk_stop[ITT_STBY_BIT];
    tb_mode = s_q.mode[ITT_TB_BIT];
    sys_run = (s_q.opmode == ITT_ACTIVE) || (s_q.opmode == ITT_SLEEP);
    mode_wr_ok = (s_q.opmode == ITT_ACTIVE) || (s_q.opmode == ITT_SUBACT);

    // --------------------------------------------------------------
    // Subclock synchroniser
    // --------------------------------------------------------------
    // Subclock is unrelated to pclk; only sub_s2 feeds the edge
    // detector, which costs up to one pclk of count-period error
    // two-stage synchroniser then edge detect
    s_d.sub_s1 = subclk_in;
    s_d.sub_s2 = s_q.sub_s1;
    s_d.sub_s3 = s_q.sub_s2;
    sub_edge = s_q.sub_s2 && !s_q.sub_s3;

    // --------------------------------------------------------------
    // Prescalers and count clock
    // --------------------------------------------------------------
    // System prescaler free running
    s_d.pss = s_q.pss + ITT_PSS_ONE;
    // time base clear holds counter and prescaler
    clr = tb_mode && s_q.mode[ITT_CLR_BIT];
    // Interval taps
    case (s_q.mode[2:0])
      3'b000: begin
        smask = ITT_PSS_D8192;
      end
      3'b001: begin
        smask = ITT_PSS_D4096;
      end
      3'b010: begin
        smask = ITT_PSS_D2048;
      end
      3'b011: begin
        smask = ITT_PSS_D512;
      end
      3'b100: begin
        smask = ITT_PSS_D256;
      end
      3'b101: begin
        smask = ITT_PSS_D128;
      end
      3'b110: begin
        smask = ITT_PSS_D32;
      end
      default: begin
        smask = ITT_PSS_D8;
      end
    endcase
    // Time base taps
    case (s_q.mode[1:0])
      2'b00: begin
        wmask = ITT_PSW_1S;
      end
      2'b01: begin
        wmask = ITT_PSW_HALF;
      end
      2'b10: begin
        wmask = ITT_PSW_QUART;
      end
      default: begin
        wmask = ITT_PSW_32ND;
      end
    endcase
    // run conditions per function and mode
    if (tb_mode) begin
      run = !stby && (s_q.opmode != ITT_STANDBY);
    end else begin
      run = !stby && sys_run;
    end
    // subclock prescaler advances on each subclock edge outside module standby and standby
    if (clr) begin
      s_d.psw = ITT_BYTE_ZERO;
    end else if (sub_edge && !stby && (s_q.opmode != ITT_STANDBY)) begin
      s_d.psw = s_q.psw + ITT_PSW_ONE;
    end
    // count tick, tap chosen by three bits (interval) or two bits (time base)
    if (tb_mode) begin
      tick = run && sub_edge && ((s_q.psw & wmask) == wmask);
    end else begin
      tick = run && ((s_q.pss & smask) == smask);
    end

    // --------------------------------------------------------------
    // Counter
    // --------------------------------------------------------------
    // Clear outranks a tick in the same cycle
    // overflow at FF, wrap to zero
    ovf = tick && !clr && (s_q.count == ITT_COUNT_MAX);
    if (clr) begin
      s_d.count = ITT_COUNT_RST;
    end else if (tick) begin
      s_d.count = s_q.count + ITT_COUNT_ONE;
    end

    // --------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------
    // Writes land at the edge that completes the access
    if (wr) begin
      case (idx)
        ITT_IDX_CLK_STOP: begin
          s_d.clk_stop = req.pwdata[7:0];
        end
        // mode register held outside active and subactive
        ITT_IDX_MODE: begin
          if (mode_wr_ok) begin
            s_d.mode = req.pwdata[7:0] & ITT_MODE_WMASK;
          end
        end
        // only the select bit is writable
        ITT_IDX_OUT_SEL: begin
          s_d.output_source_select_bit = req.pwdata[ITT_OUTPUT_SOURCE_SELECT_BIT_BIT];
        end
        ITT_IDX_IRQ_REQ: begin
          if (!req.pwdata[ITT_FLAG_BIT]) begin
            s_d.flag = 1'b0;
          end
        end
        ITT_IDX_IRQ_EN: begin
          s_d.ien = req.pwdata[ITT_IEN_BIT];
        end
        ITT_IDX_PORT_MODE: begin
          s_d.pmr = req.pwdata[ITT_PMR_BIT];
        end
        ITT_IDX_OP_MODE: begin
          if (req.pwdata[2:0] <= ITT_STANDBY) begin
            s_d.opmode = itt_opmode_type'(req.pwdata[2:0]);
          end
        end
        default: begin
          s_d.count = s_d.count;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Flag and interrupt
    // --------------------------------------------------------------
    // An overflow in the clearing cycle must not be lost
    // set wins over software clear
    if (ovf) begin
      s_d.flag = 1'b1;
    end
    s_d.irq = s_d.flag && s_d.ien;

    // --------------------------------------------------------------
    // Read mux and bus answer
    // --------------------------------------------------------------
    // Read mux
    hit = 1'b1;
    case (idx)
      ITT_IDX_CLK_STOP: begin
        rd = s_q.clk_stop;
      end
      ITT_IDX_MODE: begin
        rd = s_q.mode | ITT_MODE_RSVD;
      end
      ITT_IDX_COUNT: begin
        rd = (s_q.opmode == ITT_SUBACT) ? ITT_BYTE_ZERO : s_q.count;
      end
      ITT_IDX_OUT_SEL: begin
        rd = ITT_OUT_SEL_RSVD | {7'h00, s_q.output_source_select_bit};
      end
      ITT_IDX_IRQ_REQ: begin
        rd = {7'h00, s_q.flag};
      end
      ITT_IDX_IRQ_EN: begin
        rd = {7'h00, s_q.ien};
      end
      ITT_IDX_PORT_MODE: begin
        rd = {7'h00, s_q.pmr};
      end
      ITT_IDX_OP_MODE: begin
        rd = {5'h00, s_q.opmode};
      end
      default: begin
        rd = ITT_BYTE_ZERO;
        hit = 1'b0;
      end
    endcase
    // APB answer one cycle into the access phase
    s_d.pready = access;
    s_d.pslverr = access && !hit;
    if (access && !req.pwrite) begin
      s_d.prdata = {24'h00_0000, rd};
    end else if (!access) begin
      s_d.prdata = ITT_WORD_ZERO;
    end

    // --------------------------------------------------------------
    // Clock output pin
    // --------------------------------------------------------------
    // nine output sources
    divided = 1'b0;
    div_ok = sys_run;
    case (s_q.mode[7:5])
      3'b000: begin
        divided = s_q.pss[ITT_TAP_D32];
      end
      3'b001: begin
        divided = s_q.pss[ITT_TAP_D16];
      end
      3'b010: begin
        divided = s_q.pss[ITT_TAP_D8];
      end
      3'b011: begin
        divided = s_q.pss[ITT_TAP_D4];
      end
      3'b100: begin
        divided = s_q.psw[ITT_TAP_D32];
      end
      3'b101: begin
        divided = s_q.psw[ITT_TAP_D16];
      end
      3'b110: begin
        divided = s_q.psw[ITT_TAP_D8];
      end
      default: begin
        divided = s_q.psw[ITT_TAP_D4];
      end
    endcase
    // system taps only in active and sleep, subclock taps outside standby
    if (s_q.mode[7]) begin
      div_ok = s_q.opmode != ITT_STANDBY;
    end
    // select divided or raw subclock, raw in all modes
    if (!s_q.pmr) begin
      s_d.clk_out = 1'b0;
    end else if (s_q.output_source_select_bit) begin
      s_d.clk_out = s_q.sub_s2;
    end else begin
      // module standby freezes timer clock output while its source is available
      if (!div_ok) begin
        // Source not available in this mode: pin parks low
        s_d.clk_out = 1'b0;
      end else if (stby) begin
        // Module standby: pin holds its last level
        s_d.clk_out = s_q.clk_out;
      end else begin
        s_d.clk_out = divided;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.pss <= '0;
      s_q.psw <= ITT_BYTE_ZERO;
      s_q.sub_s1 <= 1'b0;
      s_q.sub_s2 <= 1'b0;
      s_q.sub_s3 <= 1'b0;
      // counter and mode cleared, counting resumes at once
      s_q.count <= ITT_COUNT_RST;
      s_q.mode <= ITT_MODE_RST;
      s_q.output_source_select_bit <= ITT_OUT_SEL_RST[ITT_OUTPUT_SOURCE_SELECT_BIT_BIT];
      s_q.clk_stop <= ITT_CLK_STOP_RST;
      s_q.flag <= 1'b0;
      s_q.ien <= 1'b0;
      s_q.pmr <= 1'b0;
      s_q.opmode <= ITT_ACTIVE;
      s_q.prdata <= ITT_WORD_ZERO;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.clk_out <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq_out = s_q.irq;
  assign clock_output_pin = s_q.clk_out;

endmodule

// *** rtl/itt_pkg.sv ***
package itt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [29:0] ITT_IDX_CLK_STOP = 30'h0000_FFFA;
  localparam logic [29:0] ITT_IDX_MODE = 30'h0000_FFB0;
  localparam logic [29:0] ITT_IDX_COUNT = 30'h0000_FFB1;
  localparam logic [29:0] ITT_IDX_OUT_SEL = 30'h0000_FFB2;
  localparam logic [29:0] ITT_IDX_IRQ_REQ = 30'h0000_FFB3;
  localparam logic [29:0] ITT_IDX_IRQ_EN = 30'h0000_FFB4;
  localparam logic [29:0] ITT_IDX_PORT_MODE = 30'h0000_FFB5;
  localparam logic [29:0] ITT_IDX_OP_MODE = 30'h0000_FFB6;

  // ----------------------------------------------------------------
  // Reset values and fixed bits
  // ----------------------------------------------------------------
  localparam logic [7:0] ITT_CLK_STOP_RST = 8'hFF;
  localparam logic [7:0] ITT_OUT_SEL_RST = 8'hFE;
  localparam logic [7:0] ITT_OUT_SEL_RSVD = 8'hFE;
  localparam logic [7:0] ITT_MODE_RST = 8'h00;
  localparam logic [7:0] ITT_MODE_RSVD = 8'h10;
  localparam logic [7:0] ITT_MODE_WMASK = 8'hEF;
  localparam logic [7:0] ITT_COUNT_RST = 8'h00;
  localparam logic [7:0] ITT_BYTE_ZERO = 8'h00;
  localparam logic [7:0] ITT_COUNT_MAX = 8'hFF;
  localparam logic [7:0] ITT_COUNT_ONE = 8'h01;
  localparam logic [31:0] ITT_WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ITT_STBY_BIT = 0;
  localparam int ITT_OUTPUT_SOURCE_SELECT_BIT_BIT = 0;
  localparam int ITT_FLAG_BIT = 0;
  localparam int ITT_IEN_BIT = 0;
  localparam int ITT_PMR_BIT = 0;
  localparam int ITT_TB_BIT = 3;
  localparam int ITT_CLR_BIT = 2;

  // ----------------------------------------------------------------
  // Prescaler widths and tap masks
  // ----------------------------------------------------------------
  localparam int ITT_PSS_W = 13;
  localparam int ITT_PSW_W = 8;
  localparam logic [12:0] ITT_PSS_ONE = 13'h0001;
  localparam logic [7:0] ITT_PSW_ONE = 8'h01;
  localparam logic [12:0] ITT_PSS_D8192 = 13'h1FFF;
  localparam logic [12:0] ITT_PSS_D4096 = 13'h0FFF;
  localparam logic [12:0] ITT_PSS_D2048 = 13'h07FF;
  localparam logic [12:0] ITT_PSS_D512 = 13'h01FF;
  localparam logic [12:0] ITT_PSS_D256 = 13'h00FF;
  localparam logic [12:0] ITT_PSS_D128 = 13'h007F;
  localparam logic [12:0] ITT_PSS_D32 = 13'h001F;
  localparam logic [12:0] ITT_PSS_D8 = 13'h0007;
  // Time base taps: 2 s, 1 s, 0.5 s, 0.0625 s at 32.768 kHz
  localparam logic [7:0] ITT_PSW_1S = 8'hFF;
  localparam logic [7:0] ITT_PSW_HALF = 8'h7F;
  localparam logic [7:0] ITT_PSW_QUART = 8'h3F;
  localparam logic [7:0] ITT_PSW_32ND = 8'h07;
  // Prescaler bit giving divide by 32, 16, 8, 4
  localparam int ITT_TAP_D32 = 4;
  localparam int ITT_TAP_D16 = 3;
  localparam int ITT_TAP_D8 = 2;
  localparam int ITT_TAP_D4 = 1;

  // ----------------------------------------------------------------
  // Chip operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ITT_ACTIVE = 3'b000,
    ITT_SLEEP = 3'b001,
    ITT_WATCH = 3'b010,
    ITT_SUBACT = 3'b011,
    ITT_SUBSLP = 3'b100,
    ITT_STANDBY = 3'b101
  } itt_opmode_type;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } itt_apb_req_type;

  // All block state
  typedef struct packed {
    logic [12:0] pss;
    logic [7:0] psw;
    logic sub_s1;
    logic sub_s2;
    logic sub_s3;
    logic [7:0] count;
    logic [7:0] mode;
    logic output_source_select_bit;
    logic [7:0] clk_stop;
    logic flag;
    logic ien;
    logic pmr;
    itt_opmode_type opmode;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic clk_out;
  } itt_state_type;

endpackage

// *** test/itt_timer_chk.sv ***
`timescale 1ns/100ps
module itt_timer_chk
  import itt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins
  input wire logic irq_out,
  input wire logic clock_output_pin
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr, rd, ien_q, pmr_q, sel_q, held_q;
  logic [7:0] stop_q, mode_q, cnt_q;
  logic [2:0] op_q;
  logic [29:0] idx;
  assign idx = paddr[31:2];
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  // Shadow of software settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ien_q, pmr_q, sel_q, held_q, op_q, cnt_q} <= '0;
      stop_q <= ITT_CLK_STOP_RST;
      mode_q <= ITT_MODE_RST;
    end else begin
      if (wr && idx == ITT_IDX_IRQ_EN) ien_q <= pwdata[0];
      if (wr && idx == ITT_IDX_PORT_MODE) pmr_q <= pwdata[0];
      if (wr && idx == ITT_IDX_OUT_SEL) sel_q <= pwdata[0];
      if (wr && idx == ITT_IDX_OP_MODE && pwdata[2:0] <= 3'h5) op_q <= pwdata[2:0];
      if (wr && idx == ITT_IDX_MODE && (op_q == 3'h0 || op_q == 3'h3)) mode_q <= pwdata[7:0];
      if (wr && idx == ITT_IDX_CLK_STOP) begin
        stop_q <= pwdata[7:0];
        held_q <= 1'b0;
      end
      if (rd && idx == ITT_IDX_COUNT && !stop_q[0]) begin
        held_q <= 1'b1;
        cnt_q <= prdata[7:0];
      end
    end
  end
  // One wait state, then the answer
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  a_one_wait: assert property (psel && $rose(penable) |-> s_one_wait)
    else $error("ready not after one wait");
  a_stop_read: assert property (
    rd && idx == ITT_IDX_CLK_STOP |-> prdata[7:0] == stop_q)
    else $error("clock stop readback wrong");
  a_sel_read: assert property (
    rd && idx == ITT_IDX_OUT_SEL |-> prdata[7:0] == {7'h7F, sel_q})
    else $error("output select readback wrong");
  a_mode_kept: assert property (
    rd && idx == ITT_IDX_MODE |-> prdata[7:0] == ((mode_q & ITT_MODE_WMASK) | ITT_MODE_RSVD))
    else $error("mode readback wrong");
  a_irq_gate: assert property (!ien_q && !$past(ien_q) |-> !irq_out)
    else $error("interrupt while disabled");
  a_pin_gate: assert property (!pmr_q && !$past(pmr_q) |-> !clock_output_pin)
    else $error("pin active while disabled");
  a_sub_read: assert property (
    rd && idx == ITT_IDX_COUNT && op_q == 3'h3 |-> prdata == 32'h0000_0000)
    else $error("count readable in subactive");
  a_flag_seen: assert property (
    rd && idx == ITT_IDX_IRQ_REQ && $past(irq_out) |-> prdata[0])
    else $error("interrupt without flag");
  a_count_held: assert property (
    rd && idx == ITT_IDX_COUNT && held_q |-> prdata[7:0] == cnt_q)
    else $error("count moved in module standby");
endmodule

bind itt_timer itt_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .irq_out(irq_out), .clock_output_pin(clock_output_pin));

// *** test/itt_timer_tb_top.sv ***
`timescale 1ns/100ps
module itt_timer_tb_top
  import itt_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, subclk_in, pin_q, hi, perr;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, irq_out, clock_output_pin;
  logic [7:0] v, c1;
  int num_errors, n_compared, cyc, p, t0, t1;
  int taps[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
  int tbs[4] = '{2048, 1024, 512, 64};

  itt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subclk_in(subclk_in), .irq_out(irq_out),
    .clock_output_pin(clock_output_pin));

  // ----
  // Tasks
  // ----
  task automatic end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [29:0] i, input logic [7:0] d,
    output logic [7:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [29:0] i, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, i, d, r);
  endtask
  task automatic rd(input logic [29:0] i, output logic [7:0] r);
    xfer(1'b0, i, 8'h00, r);
  endtask
  task automatic rdc(input string nm, input logic [29:0] i, input logic [7:0] e);
    logic [7:0] r;
    rd(i, r);
    chk(nm, r, e);
  endtask
  // Pin period, rise to rise; 0 when the pin is quiet
  task automatic per(output int r);
    for (int k = 0; k < 3; k++) begin
      r = 0;
      do begin
        @(posedge pclk);
        r++;
      end while (!(clock_output_pin === 1'b1 && pin_q === 1'b0) && r < 600);
    end
    if (r >= 600) r = 0;
  endtask
  // Cycles between two counter steps
  task automatic cper(output int r);
    logic [7:0] a, b;
    rd(ITT_IDX_COUNT, a);
    b = a;
    while (b === a) rd(ITT_IDX_COUNT, b);
    r = cyc;
    a = b;
    while (b === a) rd(ITT_IDX_COUNT, b);
    r = cyc - r;
  endtask
  // Clear the flag, then time the next rise of the interrupt
  task automatic wt_irq(output int t);
    wr(ITT_IDX_IRQ_REQ, 8'h00);
    do @(posedge pclk); while (irq_out !== 1'b1);
    t = cyc;
  endtask

  // Clocks; subclock free running, unrelated phase
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    subclk_in = 1'b0;
    #3;
    forever #40 subclk_in = ~subclk_in;
  end
  // Cycle count and hang guard
  always @(posedge pclk) begin
    pin_q <= clock_output_pin;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      num_errors++;
      end_sim;
    end
  end

  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} <= 4'h0;
    paddr <= 32'h0000_0000;
    pwdata <= 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("stop", ITT_IDX_CLK_STOP, 8'hFF);
    rdc("outsel", ITT_IDX_OUT_SEL, 8'hFE);
    rdc("mode", ITT_IDX_MODE, 8'h10);
    rdc("count", ITT_IDX_COUNT, 8'h00);
    wr(ITT_IDX_OUT_SEL, 8'h00);
    rdc("outsel", ITT_IDX_OUT_SEL, 8'hFE);
    wr(ITT_IDX_OUT_SEL, 8'hFF);
    rdc("outsel", ITT_IDX_OUT_SEL, 8'hFF);
    wr(ITT_IDX_PORT_MODE, 8'h01);
    per(p);
    chk("raw period", p, 8);
    wr(ITT_IDX_OUT_SEL, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(ITT_IDX_MODE, 8'(s << 5));
      per(p);
      chk("src period", p, s < 4 ? 32 >> s : 256 >> (s - 4));
    end
    wr(ITT_IDX_OP_MODE, 8'h02);
    per(p);
    chk("watch sub", p, 32);
    wr(ITT_IDX_OP_MODE, 8'h00);
    wr(ITT_IDX_MODE, 8'h60);
    wr(ITT_IDX_OP_MODE, 8'h02);
    per(p);
    chk("watch sys", p, 0);
    wr(ITT_IDX_MODE, 8'h07);
    rdc("mode kept", ITT_IDX_MODE, 8'h70);
    wr(ITT_IDX_OP_MODE, 8'h00);
    wr(ITT_IDX_PORT_MODE, 8'h00);
    per(p);
    chk("pin off", p, 0);
    for (int i = 0; i < 8; i++) begin
      wr(ITT_IDX_MODE, 8'(i));
      cper(p);
      chk("tick", p > taps[i] - 6 && p < taps[i] + 6, 1);
    end
    wr(ITT_IDX_IRQ_REQ, 8'h00);
    wr(ITT_IDX_IRQ_EN, 8'h01);
    wt_irq(t0);
    rd(ITT_IDX_IRQ_REQ, v);
    chk("flag", v[0], 1'b1);
    wr(ITT_IDX_IRQ_REQ, 8'h00);
    wt_irq(t1);
    chk("ovf period", t1 - t0, 2048);
    wr(ITT_IDX_IRQ_EN, 8'h00);
    wr(ITT_IDX_IRQ_REQ, 8'h00);
    hi = 1'b0;
    repeat (2100) begin
      @(posedge pclk);
      hi = hi | irq_out;
    end
    chk("irq gated", hi, 1'b0);
    rd(ITT_IDX_IRQ_REQ, v);
    chk("flag", v[0], 1'b1);
    wr(ITT_IDX_CLK_STOP, 8'hFE);
    rdc("stop", ITT_IDX_CLK_STOP, 8'hFE);
    rd(ITT_IDX_COUNT, c1);
    wr(ITT_IDX_COUNT, 8'h5A);
    chk("count wr err", perr, 1'b0);
    repeat (40) @(posedge pclk);
    rdc("frozen", ITT_IDX_COUNT, c1);
    wr(ITT_IDX_CLK_STOP, 8'hFF);
    wr(ITT_IDX_OP_MODE, 8'h03);
    rdc("sub read", ITT_IDX_COUNT, 8'h00);
    wr(ITT_IDX_OP_MODE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ITT_IDX_MODE, 8'(8 + i));
      cper(p);
      chk("tbase", p > tbs[i] - 6 && p < tbs[i] + 6, 1);
    end
    wr(ITT_IDX_MODE, 8'h0F);
    repeat (100) @(posedge pclk);
    rdc("cleared", ITT_IDX_COUNT, 8'h00);
    end_sim;
  end
endmodule
